/* design/ccw_cfg.svh */
`ifndef CCW_CFG_SVH
`define CCW_CFG_SVH

// Register indices; the byte address is four times the index
`define CCW_IDX_AREA0_CTRL   8'hc0
`define CCW_IDX_AREA1_CTRL   8'hc1
`define CCW_IDX_AREA2_CTRL   8'hc2
`define CCW_IDX_AREA3_CTRL   8'hc3
`define CCW_IDX_DEFAULT_CTRL 8'hc7
`define CCW_IDX_START_BASE   8'hd0
`define CCW_IDX_MASK_BASE    8'hd4
`define CCW_IDX_STATUS       8'he0

// Control field positions
`define CCW_BIT_ENABLE       7
`define CCW_BIT_RANGE_SEL    6
`define CCW_BIT_WAVE_HI      5
`define CCW_BIT_WAVE_LO      4
`define CCW_BIT_WIDTH        3
`define CCW_BIT_WAIT_HI      2
`define CCW_BIT_WAIT_LO      0

// Writable bit masks
`define CCW_AREA_WMASK       8'hbf
`define CCW_AREA2_WMASK      8'hff
`define CCW_DEFAULT_WMASK    8'h0f

// Reset values
`define CCW_RST_AREA_CTRL    8'h00
`define CCW_RST_AREA2_CTRL   8'h80
`define CCW_RST_DEFAULT_CTRL 8'h00
`define CCW_RST_START        8'hff
`define CCW_RST_MASK         8'h00

// Address map
`define CCW_INT_TOP          24'h002000
`define CCW_AREA2_LO         24'h002000
`define CCW_AREA2_HI         24'hfdffff

// Wait codes
`define CCW_WAIT_2           3'h0
`define CCW_WAIT_1           3'h1
`define CCW_WAIT_1N          3'h2
`define CCW_WAIT_0           3'h3
`define CCW_WAIT_RSVD        3'h4
`define CCW_WAIT_3           3'h5
`define CCW_WAIT_4           3'h6
`define CCW_WAIT_8           3'h7

// Operand sizes
`define CCW_SIZE_BYTE        2'h0
`define CCW_SIZE_HALF        2'h1
`define CCW_SIZE_WORD        2'h2

`endif

/* design/ccw_pkg.sv */
package ccw_pkg;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_WAIT  = 5'b00100,
        ST_END   = 5'b01000,
        ST_DONE  = 5'b10000
    } ccw_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } ccw_cpu_req_t;

    typedef struct packed {
        logic [23:0] addr;
        logic        rd_n;
        logic        wr_lo_n;
        logic        wr_hi_n;
        logic [15:0] dout;
        logic [1:0]  doe;
    } ccw_mem_out_t;

endpackage : ccw_pkg

/* design/ccw_area_decode.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ccw_cfg.svh"

module ccw_area_decode #(
    parameter bit FIXED_RANGE_OK = 1'b0
) (
    input  wire logic [7:0]  ctrl_i,
    input  wire logic [7:0]  start_i,
    input  wire logic [7:0]  mask_i,
    input  wire logic [23:0] addr_i,
    output logic             hit_o
);

    logic match_window;
    logic match_fixed;

    assign match_window = ((addr_i[23:16] ^ start_i) & ~mask_i) == 8'h00;
    assign match_fixed  = addr_i >= `CCW_AREA2_LO
                    && addr_i <= `CCW_AREA2_HI;

    always_comb begin
        hit_o = 1'b0;
        if (ctrl_i[`CCW_BIT_ENABLE]) begin
            if (FIXED_RANGE_OK && !ctrl_i[`CCW_BIT_RANGE_SEL]) begin
                hit_o = match_fixed;
            end else begin
                hit_o = match_window;
            end
        end
    end

endmodule : ccw_area_decode
`default_nettype wire

/* design/ccw_wait_ctr.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ccw_cfg.svh"

module ccw_wait_ctr (
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    input  wire logic       load_i,
    input  wire logic       run_i,
    input  wire logic [2:0] code_i,
    input  wire logic       ext_wait_n_i,
    output logic            none_o,
    output logic            last_o
);

    logic [3:0] cnt_reg;
    logic       ext_reg;
    logic [3:0] load_val;

    always_comb begin
        unique case (code_i)
            `CCW_WAIT_2:  load_val = 4'h2;
            `CCW_WAIT_1:  load_val = 4'h1;
            `CCW_WAIT_1N: load_val = 4'h1;
            `CCW_WAIT_0:  load_val = 4'h0;
            `CCW_WAIT_3:  load_val = 4'h3;
            `CCW_WAIT_4:  load_val = 4'h4;
            `CCW_WAIT_8:  load_val = 4'h8;
            default:      load_val = 4'h0;
        endcase
    end

    assign none_o = load_val == 4'h0;
    // Extended mode holds the last wait while the pin is low
    assign last_o = (cnt_reg <= 4'h1) && (!ext_reg || ext_wait_n_i);

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 4'h0;
            ext_reg <= 1'b0;
        end else if (ce_i) begin
            if (load_i) begin
                cnt_reg <= load_val;
                ext_reg <= code_i == `CCW_WAIT_1N;
            end else if (run_i && cnt_reg > 4'h1) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end

endmodule : ccw_wait_ctr
`default_nettype wire

/* design/ccw_chip_select_wait_control.sv */
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "ccw_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module ccw_chip_select_wait_control (
    input  wire logic                  sys_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  ce_i,
    // APB slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [9:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic [31:0]                prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // CPU core side
    input  wire ccw_pkg::ccw_cpu_req_t cpu_req_i,
    output logic                       cpu_ready_o,
    output logic                       cpu_done_o,
    output logic                       cpu_internal_o,
    output logic [31:0]                cpu_rdata_o,
    // External memory side
    output ccw_pkg::ccw_mem_out_t      mem_o,
    input  wire logic [15:0]           mem_din_i,
    input  wire logic                  mem_wait_n_i,
    output logic [3:0]                 area_select_out_n_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  area_ctrl_reg [4];
    logic [7:0]  default_area_ctrl_reg;
    logic [7:0]  area_start_addr_reg [4];
    logic [7:0]  area_addr_mask_reg [4];
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    logic        apb_setup;
    logic        apb_write;
    logic [7:0]  apb_idx;
    logic        idx_ctrl;
    logic        idx_start;
    logic        idx_mask;
    logic        idx_known;

    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pwrite_i && ce_i;
    assign apb_idx   = paddr_i[9:2];
    assign idx_ctrl  = apb_idx[7:2] == `CCW_IDX_AREA0_CTRL >> 2;
    assign idx_start = apb_idx[7:2] == `CCW_IDX_START_BASE >> 2;
    assign idx_mask  = apb_idx[7:2] == `CCW_IDX_MASK_BASE >> 2;
    assign idx_known = idx_ctrl || idx_start || idx_mask
                    || apb_idx == `CCW_IDX_DEFAULT_CTRL
                    || apb_idx == `CCW_IDX_STATUS;

    assign pready_o  = ce_i;
    assign prdata_o  = prdata_reg;
    assign pslverr_o = pslverr_reg && psel_i && penable_i;

    // Area control writes
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            area_ctrl_reg[0]      <= `CCW_RST_AREA_CTRL;
            area_ctrl_reg[1]      <= `CCW_RST_AREA_CTRL;
            area_ctrl_reg[2]      <= `CCW_RST_AREA2_CTRL;
            area_ctrl_reg[3]      <= `CCW_RST_AREA_CTRL;
            default_area_ctrl_reg <= `CCW_RST_DEFAULT_CTRL;
        end else if (apb_write && !pslverr_reg) begin
            if (idx_ctrl) begin
                if (apb_idx[1:0] == 2'h2) begin
                    area_ctrl_reg[2] <= pwdata_i[7:0] & `CCW_AREA2_WMASK;
                end else begin
                    area_ctrl_reg[apb_idx[1:0]] <= pwdata_i[7:0]
                                                 & `CCW_AREA_WMASK;
                end
            end
            if (apb_idx == `CCW_IDX_DEFAULT_CTRL) begin
                default_area_ctrl_reg <= pwdata_i[7:0] & `CCW_DEFAULT_WMASK;
            end
        end
    end

    // Start address and mask writes
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 4; i++) begin
                area_start_addr_reg[i] <= `CCW_RST_START;
                area_addr_mask_reg[i]  <= `CCW_RST_MASK;
            end
        end else if (apb_write && !pslverr_reg) begin
            if (idx_start) begin
                area_start_addr_reg[apb_idx[1:0]] <= pwdata_i[7:0];
            end
            if (idx_mask) begin
                area_addr_mask_reg[apb_idx[1:0]] <= pwdata_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer state
    ccw_pkg::ccw_state_t state_reg;
    ccw_pkg::ccw_state_t state_next;
    logic [23:0] cur_addr_reg;
    logic [2:0]  left_reg;
    logic [1:0]  ptr_reg;
    logic        write_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic        internal_reg;
    logic [1:0]  step;
    logic        lane_lo;
    logic        lane_hi;
    logic        wait_none;
    logic        wait_last;

    // APB read data and error capture
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (ce_i && apb_setup) begin
            pslverr_reg <= !idx_known;
            prdata_reg  <= 32'h0000_0000;
            if (idx_start) begin
                prdata_reg[7:0] <= area_start_addr_reg[apb_idx[1:0]];
            end else if (idx_mask) begin
                prdata_reg[7:0] <= area_addr_mask_reg[apb_idx[1:0]];
            end else if (apb_idx == `CCW_IDX_STATUS) begin
                prdata_reg[7:0] <= {~area_select_out_n_o, 2'b00,
                    internal_reg, state_reg != ccw_pkg::ST_IDLE};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    logic [3:0] area_hit;
    logic       int_hit;
    logic [1:0] hit_idx;
    logic       any_hit;
    logic [7:0] eff_ctrl;
    logic       eff_8bit;

    for (genvar g = 0; g < 4; g++) begin : g_area
        ccw_area_decode #(
            .FIXED_RANGE_OK (g == 2)
        ) u_decode (
            .ctrl_i  (area_ctrl_reg[g]),
            .start_i (area_start_addr_reg[g]),
            .mask_i  (area_addr_mask_reg[g]),
            .addr_i  (cur_addr_reg),
            .hit_o   (area_hit[g])
        );
    end

    assign int_hit = cur_addr_reg < `CCW_INT_TOP;

    always_comb begin
        hit_idx = 2'h0;
        any_hit = 1'b0;
        for (int i = 3; i >= 0; i--) begin
            if (area_hit[i]) begin
                hit_idx = 2'(i);
                any_hit = 1'b1;
            end
        end
    end

    // Disabled or missed areas fall back to the default register
    assign eff_ctrl = any_hit ? area_ctrl_reg[hit_idx]
                              : default_area_ctrl_reg;
    assign eff_8bit = eff_ctrl[`CCW_BIT_WIDTH];

    ////////////////////////////////////////////////////////////////////////////
    // Dynamic bus sizing
    always_comb begin
        step    = 2'h1;
        lane_lo = 1'b0;
        lane_hi = 1'b0;
        if (eff_8bit) begin
            lane_lo = 1'b1;
        end else if (cur_addr_reg[0]) begin
            lane_hi = 1'b1;
        end else if (left_reg >= 3'h2) begin
            step    = 2'h2;
            lane_lo = 1'b1;
            lane_hi = 1'b1;
        end else begin
            lane_lo = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wait pin synchroniser and wait counter
    logic wait_n_meta_reg;
    logic wait_n_sync_reg;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wait_n_meta_reg <= 1'b1;
            wait_n_sync_reg <= 1'b1;
        end else if (ce_i) begin
            wait_n_meta_reg <= mem_wait_n_i;
            wait_n_sync_reg <= wait_n_meta_reg;
        end
    end

    ccw_wait_ctr u_wait (
        .sys_clk_i    (sys_clk_i),
        .sys_rst_i    (sys_rst_i),
        .ce_i         (ce_i),
        .load_i       (state_reg == ccw_pkg::ST_SETUP),
        .run_i        (state_reg == ccw_pkg::ST_WAIT),
        .code_i       (eff_ctrl[`CCW_BIT_WAIT_HI:`CCW_BIT_WAIT_LO]),
        .ext_wait_n_i (wait_n_sync_reg),
        .none_o       (wait_none),
        .last_o       (wait_last)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign cpu_ready_o = ce_i && state_reg == ccw_pkg::ST_IDLE;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ccw_pkg::ST_IDLE: begin
                if (cpu_ready_o && cpu_req_i.valid) begin
                    state_next = ccw_pkg::ST_SETUP;
                end
            end
            ccw_pkg::ST_SETUP: begin
                if (int_hit) begin
                    state_next = ccw_pkg::ST_DONE;
                end else if (wait_none) begin
                    state_next = ccw_pkg::ST_END;
                end else begin
                    state_next = ccw_pkg::ST_WAIT;
                end
            end
            ccw_pkg::ST_WAIT: begin
                if (wait_last) begin
                    state_next = ccw_pkg::ST_END;
                end
            end
            ccw_pkg::ST_END: begin
                if (left_reg == 3'(step)) begin
                    state_next = ccw_pkg::ST_DONE;
                end else begin
                    state_next = ccw_pkg::ST_SETUP;
                end
            end
            ccw_pkg::ST_DONE: begin
                state_next = ccw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= ccw_pkg::ST_IDLE;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    // Operand bookkeeping
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cur_addr_reg <= 24'h00_0000;
            left_reg     <= 3'h0;
            ptr_reg      <= 2'h0;
            write_reg    <= 1'b0;
            wdata_reg    <= 32'h0000_0000;
            internal_reg <= 1'b0;
        end else if (ce_i) begin
            if (state_reg == ccw_pkg::ST_IDLE && cpu_req_i.valid) begin
                cur_addr_reg <= cpu_req_i.addr;
                ptr_reg      <= 2'h0;
                write_reg    <= cpu_req_i.write;
                wdata_reg    <= cpu_req_i.wdata;
                unique case (cpu_req_i.size)
                    `CCW_SIZE_HALF: left_reg <= 3'h2;
                    `CCW_SIZE_WORD: left_reg <= 3'h4;
                    default:        left_reg <= 3'h1;
                endcase
            end
            if (state_reg == ccw_pkg::ST_SETUP) begin
                internal_reg <= int_hit;
            end
            if (state_reg == ccw_pkg::ST_END) begin
                cur_addr_reg <= cur_addr_reg + 24'(step);
                ptr_reg      <= ptr_reg + step;
                left_reg     <= left_reg - 3'(step);
            end
        end
    end

    // Read data assembly, low byte first
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            if (state_reg == ccw_pkg::ST_IDLE && cpu_req_i.valid) begin
                rdata_reg <= 32'h0000_0000;
            end else if (state_reg == ccw_pkg::ST_END && !write_reg) begin
                if (lane_lo && lane_hi) begin
                    rdata_reg[ptr_reg*8 +: 16] <= mem_din_i;
                end else if (lane_hi) begin
                    rdata_reg[ptr_reg*8 +: 8] <= mem_din_i[15:8];
                end else begin
                    rdata_reg[ptr_reg*8 +: 8] <= mem_din_i[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External bus outputs
    logic [7:0] wbyte0;
    logic [7:0] wbyte1;
    logic       in_cycle;

    assign wbyte0   = wdata_reg[ptr_reg*8 +: 8];
    assign wbyte1   = wdata_reg[(2'(ptr_reg + 2'h1))*8 +: 8];
    assign in_cycle = state_next == ccw_pkg::ST_WAIT
                   || state_next == ccw_pkg::ST_END;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mem_o.addr          <= 24'h00_0000;
            mem_o.rd_n          <= 1'b1;
            mem_o.wr_lo_n       <= 1'b1;
            mem_o.wr_hi_n       <= 1'b1;
            mem_o.dout          <= 16'h0000;
            mem_o.doe           <= 2'h0;
            area_select_out_n_o <= 4'hf;
        end else if (ce_i) begin
            mem_o.rd_n    <= 1'b1;
            mem_o.wr_lo_n <= 1'b1;
            mem_o.wr_hi_n <= 1'b1;
            mem_o.doe     <= 2'h0;
            area_select_out_n_o <= 4'hf;
            if (in_cycle && !int_hit) begin
                mem_o.addr    <= cur_addr_reg;
                mem_o.rd_n    <= write_reg;
                mem_o.wr_lo_n <= !(write_reg && lane_lo);
                mem_o.wr_hi_n <= !(write_reg && lane_hi);
                mem_o.doe     <= {write_reg && lane_hi,
                                  write_reg && lane_lo};
                if (lane_lo && lane_hi) begin
                    mem_o.dout <= {wbyte1, wbyte0};
                end else if (lane_hi) begin
                    mem_o.dout <= {wbyte0, 8'h00};
                end else begin
                    mem_o.dout <= {8'h00, wbyte0};
                end
                if (any_hit) begin
                    area_select_out_n_o[hit_idx] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU answer
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cpu_done_o     <= 1'b0;
            cpu_internal_o <= 1'b0;
            cpu_rdata_o    <= 32'h0000_0000;
        end else if (ce_i) begin
            cpu_done_o <= state_reg == ccw_pkg::ST_DONE;
            if (state_reg == ccw_pkg::ST_DONE) begin
                cpu_internal_o <= internal_reg;
                cpu_rdata_o    <= rdata_reg;
            end
        end
    end

endmodule : ccw_chip_select_wait_control
`default_nettype wire

/* verif/ccw_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none

module ccw_mem_model (
    input  wire logic                  sys_clk_i,
    input  wire ccw_pkg::ccw_mem_out_t mem_i,
    input  wire logic                  narrow_i,
    input  wire logic [3:0]            stall_i,
    output logic [15:0]                din_o,
    output logic                       wait_n_o
);
    logic [7:0]  mem [256];
    logic [7:0]  lo, hi;
    logic [15:0] rdat;
    logic [15:0] last_reg = 16'h0;
    logic [3:0]  cnt_reg = 4'h0;
    logic        act;

    ////////////////////////////////////////////////////////////////////////////
    assign act = !(mem_i.rd_n && mem_i.wr_lo_n && mem_i.wr_hi_n);
    assign lo = narrow_i ? mem_i.addr[7:0] : {mem_i.addr[7:1], 1'h0};
    assign hi = {mem_i.addr[7:1], 1'h1};
    // Idle lanes show the inverse of the last value
    assign rdat = narrow_i ? {~last_reg[15:8], mem[lo]} : {mem[hi], mem[lo]};
    assign din_o = mem_i.rd_n ? ~last_reg : rdat;
    // Wait stays low for stall_i strobe cycles
    assign wait_n_o = cnt_reg >= stall_i;

    always_ff @(posedge sys_clk_i) begin
        last_reg <= din_o;
        cnt_reg <= act ? cnt_reg + {3'h0, cnt_reg != 4'hf} : 4'h0;
        if (!mem_i.wr_lo_n) mem[lo] <= mem_i.dout[7:0];
        if (!mem_i.wr_hi_n) mem[hi] <= mem_i.dout[15:8];
    end
endmodule : ccw_mem_model

`default_nettype wire

/* verif/ccw_assertions.sv */
`timescale 1ns/10ps
`default_nettype none

module ccw_assertions (
    input wire logic                  sys_clk_i,
    input wire logic                  sys_rst_i,
    input wire logic                  cpu_done_o,
    input wire logic                  cpu_internal_o,
    input wire ccw_pkg::ccw_mem_out_t mem_o,
    input wire logic [3:0]            area_select_out_n_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    ////////////////////////////////////////////////////////////////////////////
    a_sel_one_hot: assert property ($onehot0(~area_select_out_n_o))
        else $error("two area selects active");
    a_sel_idle_done: assert property (cpu_done_o
        |-> area_select_out_n_o == 4'hf) else $error("select past end");
    a_sel_steady: assert property (!mem_o.rd_n && !$past(mem_o.rd_n)
        |-> $stable(area_select_out_n_o)) else $error("select moved");
    a_wr_lo_drv: assert property (!mem_o.wr_lo_n |-> mem_o.doe[0])
        else $error("low strobe on floating lane");
    a_wr_hi_drv: assert property (!mem_o.wr_hi_n |-> mem_o.doe[1])
        else $error("high strobe on floating lane");
    a_rd_lanes_float: assert property (!mem_o.rd_n |-> !mem_o.doe
        && mem_o.wr_lo_n && mem_o.wr_hi_n) else $error("lane driven in read");
    a_odd_high_lane: assert property (!mem_o.wr_hi_n && mem_o.wr_lo_n
        |-> mem_o.addr[0]) else $error("high lane alone at even address");
    a_even_half: assert property (!mem_o.wr_hi_n && !mem_o.wr_lo_n
        |-> !mem_o.addr[0]) else $error("halfword at odd address");
    a_int_no_bus: assert property (cpu_done_o && cpu_internal_o
        |-> $past(area_select_out_n_o, 2) == 4'hf && $past(mem_o.rd_n, 2))
        else $error("bus activity on internal access");
    c_split_write: cover property (!mem_o.wr_hi_n && !mem_o.wr_lo_n);
    c_internal: cover property (cpu_done_o && cpu_internal_o);
    c_area0: cover property (!area_select_out_n_o[0]);
endmodule : ccw_assertions

`default_nettype wire

/* verif/ccw_chip_select_wait_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ccw_cfg.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end

module ccw_chip_select_wait_control_bench;
    logic                  clk = 1'h0;
    logic                  rst = 1'h1;
    logic                  psel = 1'h0, penable = 1'h0;
    logic                  pwrite = 1'h0, narrow = 1'h0;
    logic                  pready, pslverr, cready, cdone, cint, wait_n, e;
    logic [9:0]            paddr = 10'h0;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata, crdata;
    logic [15:0]           din;
    logic [3:0]            sel_n, sel_seen;
    logic [3:0]            stall = 4'h0;
    ccw_pkg::ccw_cpu_req_t req = 60'h0;
    ccw_pkg::ccw_mem_out_t mem;
    logic [23:0]           aq [$];
    logic [1:0]            dq [$];
    int                    err_count = 0;
    int                    checks_done = 0;
    int                    na, len, i;
    logic [2:0]            wc [6] = '{`CCW_WAIT_2, `CCW_WAIT_1, `CCW_WAIT_0,
                                      `CCW_WAIT_3, `CCW_WAIT_4, `CCW_WAIT_8};
    int                    wn [6] = '{2, 1, 0, 3, 4, 8};

    ccw_chip_select_wait_control u_dut (.sys_clk_i(clk), .sys_rst_i(rst),
        .ce_i(1'h1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cpu_req_i(req),
        .cpu_ready_o(cready), .cpu_done_o(cdone), .cpu_internal_o(cint),
        .cpu_rdata_o(crdata), .mem_o(mem), .mem_din_i(din),
        .mem_wait_n_i(wait_n), .area_select_out_n_o(sel_n));
    ccw_mem_model u_mem (.sys_clk_i(clk), .mem_i(mem), .narrow_i(narrow),
        .stall_i(stall), .din_o(din), .wait_n_o(wait_n));

    ////////////////////////////////////////////////////////////////////////////
    initial forever #5 clk = ~clk;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic tmo;
        err_count++;
        stop_test();
    endtask : tmo

    // Plain reads and writes; waveform 00; code 100 never used
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        if (i >= 20) tmo();
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb

    task automatic op(input logic w, input logic [1:0] sz,
                      input logic [23:0] ad, input logic [31:0] wd);
        logic s, p;
        req <= {1'h1, w, sz, ad, wd};
        @(posedge clk);
        req.valid <= 1'h0;
        na = 0;
        len = 0;
        sel_seen = 4'h0;
        p = 1'h0;
        aq.delete();
        dq.delete();
        i = 0;
        do begin
            @(negedge clk);
            s = !(mem.rd_n && mem.wr_lo_n && mem.wr_hi_n);
            if (s && !p) begin
                na++;
                aq.push_back(mem.addr);
                dq.push_back(mem.doe);
            end
            if (s && na == 1) len++;
            sel_seen |= ~sel_n;
            p = s;
            i++;
        end while (cdone !== 1'h1 && i < 200);
        if (i >= 200) tmo();
        @(posedge clk);
    endtask : op

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        op(1'h0, `CCW_SIZE_BYTE, 24'h002100, 32'h0);
        `CHK("rst sel", 4'h4, sel_seen)
        `CHK("rst len", 3, len)
        $display("test reset done");
        stall <= 4'hf;
        foreach (wc[k]) begin
            apb(1'h1, `CCW_IDX_AREA2_CTRL, {5'h10, wc[k]});
            op(1'h0, `CCW_SIZE_BYTE, 24'h002100, 32'h0);
            `CHK("fixed len", wn[k] + 1, len)
        end
        apb(1'h1, `CCW_IDX_AREA2_CTRL, {5'h10, `CCW_WAIT_1N});
        stall <= 4'h0;
        op(1'h0, `CCW_SIZE_BYTE, 24'h002100, 32'h0);
        `CHK("pin high len", 2, len)
        stall <= 4'h6;
        op(1'h0, `CCW_SIZE_BYTE, 24'h002100, 32'h0);
        `CHK("pin low len", 1'h1, len >= 7 && len <= 11)
        stall <= 4'h0;
        $display("test waits done");
        apb(1'h1, `CCW_IDX_AREA2_CTRL, 8'h83);
        op(1'h1, `CCW_SIZE_WORD, 24'h002111, 32'h44332211);
        `CHK("wide n", 3, na)
        `CHK("wide a2", 24'h002114, aq[2])
        `CHK("wide lanes", 6'h2d, {dq[0], dq[1], dq[2]})
        op(1'h0, `CCW_SIZE_WORD, 24'h002111, 32'h0);
        `CHK("wide data", 32'h44332211, crdata)
        apb(1'h1, `CCW_IDX_AREA2_CTRL, 8'h8b);
        narrow <= 1'h1;
        op(1'h1, `CCW_SIZE_WORD, 24'h002221, 32'h88776655);
        `CHK("narrow n", 4, na)
        `CHK("narrow a3", 24'h002224, aq[3])
        `CHK("narrow lanes", 8'h55, {dq[0], dq[1], dq[2], dq[3]})
        op(1'h0, `CCW_SIZE_WORD, 24'h002221, 32'h0);
        `CHK("narrow data", 32'h88776655, crdata)
        $display("test sizing done");
        apb(1'h1, `CCW_IDX_AREA2_CTRL, 8'h03);
        apb(1'h1, `CCW_IDX_DEFAULT_CTRL, 8'h0d);
        op(1'h0, `CCW_SIZE_HALF, 24'h002300, 32'h0);
        `CHK("dflt sel", 4'h0, sel_seen)
        `CHK("dflt n", 2, na)
        `CHK("dflt len", 4, len)
        $display("test default done");
        // Start, then mask, then control
        apb(1'h1, `CCW_IDX_START_BASE + 8'h2, 8'h40);
        apb(1'h1, `CCW_IDX_MASK_BASE + 8'h2, 8'h00);
        apb(1'h1, `CCW_IDX_AREA2_CTRL, 8'hc3);
        op(1'h0, `CCW_SIZE_BYTE, 24'h002300, 32'h0);
        `CHK("win miss", 4'h0, sel_seen)
        op(1'h0, `CCW_SIZE_BYTE, 24'h400010, 32'h0);
        `CHK("win hit", 4'h4, sel_seen)
        `CHK("win len", 1, len)
        apb(1'h0, `CCW_IDX_START_BASE + 8'h2, 8'h00);
        `CHK("start rd", 32'h40, prdata)
        apb(1'h1, `CCW_IDX_START_BASE, 8'h01);
        apb(1'h1, `CCW_IDX_AREA0_CTRL, 8'h83);
        op(1'h0, `CCW_SIZE_BYTE, 24'h010000, 32'h0);
        `CHK("area0 sel", 4'h1, sel_seen)
        $display("test windows done");
        op(1'h0, `CCW_SIZE_BYTE, 24'h000100, 32'h0);
        `CHK("int flag", 1'h1, cint)
        `CHK("int bus", 0, na)
        apb(1'h1, 8'h10, 8'h55);
        `CHK("unmapped err", 1'h1, e)
        $display("test internal done");
        stop_test();
    end
endmodule : ccw_chip_select_wait_control_bench

bind ccw_chip_select_wait_control ccw_assertions u_chk (.sys_clk_i,
    .sys_rst_i, .cpu_done_o, .cpu_internal_o, .mem_o, .area_select_out_n_o);

`default_nettype wire
